//--- fwsr_pkg.sv
/*
 Package of the flash status-polling controller: pin bundle, timing counts,
 own register map, operation codes, result codes and state encodings.
 Assumes a 50 MHz system clock and a byte-wide parallel flash bus.
*/
`default_nettype none
package fwsr_pkg;

	// ----------------------------------------------------------------
	// Clock and flash bus timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 50;
	localparam int RD_ACC_NS = 70;
	localparam int WR_PULSE_NS = 45;
	localparam int RECOVER_NS = 20;
	localparam logic [3:0] RD_ACC_CYC = 4'((RD_ACC_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] WR_PULSE_CYC = 4'((WR_PULSE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0] RECOVER_CYC = 4'((RECOVER_NS * CLK_MHZ + 999) / 1000);

	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;

	// ----------------------------------------------------------------
	// Positions inside the flash status byte
	// ----------------------------------------------------------------
	localparam int COMPLETION_POLL_BIT = 7;
	localparam int ACTIVITY_TOGGLE_BIT = 6;
	localparam int TIMEOUT_FAIL_FLAG = 5;
	localparam int ERASE_WINDOW_FLAG = 3;
	localparam int SECTOR_TOGGLE_BIT = 2;

	localparam logic [DATA_W-1:0] RESET_CMD_DATA = 8'hf0;

	// ----------------------------------------------------------------
	// Own registers (byte addresses on AXI4-Lite)
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_ADDR = 4'h4;
	localparam logic [3:0] OFS_WDATA = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hc;

	localparam int CTRL_GO_BIT = 0;
	localparam int CTRL_OP_LSB = 1;
	localparam int CTRL_AUTORST_BIT = 3;
	localparam int CTRL_ABORT_BIT = 4;

	localparam int ST_BUSY_BIT = 0;
	localparam int ST_DONE_BIT = 1;
	localparam int ST_RES_LSB = 2;
	localparam int ST_RDY_BIT = 5;
	localparam int ST_REJ_BIT = 6;
	localparam int ST_EWIN_BIT = 7;
	localparam int ST_RDATA_LSB = 8;
	localparam int ST_ACC_BIT = 16;
	localparam int ST_PRE_BIT = 17;

	localparam logic [ADDR_W-1:0] ADDR_RESET = 19'h00000;
	localparam logic [DATA_W-1:0] WDATA_RESET = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_WRITE = 2'h0,
		OP_READ = 2'h1,
		OP_POLL = 2'h2,
		OP_CHECKED = 2'h3
	} fwsr_op_t;

	typedef enum logic [2:0] {
		RES_NONE = 3'h0,
		RES_DONE = 3'h1,
		RES_SUSPENDED = 3'h2,
		RES_FAIL = 3'h3,
		RES_FAIL_RESET = 3'h4,
		RES_ABORTED = 3'h5,
		RES_XFER = 3'h6,
		RES_CHECKED = 3'h7
	} fwsr_res_t;

	typedef enum logic [6:0] {
		S_IDLE = 7'b0000001,
		S_PRE = 7'b0000010,
		S_WR = 7'b0000100,
		S_RD1 = 7'b0001000,
		S_RD2 = 7'b0010000,
		S_EVAL = 7'b0100000,
		S_RST = 7'b1000000
	} fwsr_state_t;

	typedef enum logic [3:0] {
		C_IDLE = 4'b0001,
		C_SETUP = 4'b0010,
		C_STROBE = 4'b0100,
		C_RECOVER = 4'b1000
	} fwsr_cyc_state_t;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic dq_oe;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq;
	} fwsr_pins_t;

	localparam fwsr_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_oe: 1'b0,
		addr: 19'h00000, dq: 8'h00};

endpackage
`default_nettype wire

//--- fwsr_bus_cycle.sv
/*
 One asynchronous flash bus cycle (read or write) built from clock counts.
 Assumes the flash pins are driven straight from o_pins and that i_dq is
 already synchronous to i_clk.
*/
`default_nettype none
module fwsr_bus_cycle (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_start,
	input wire logic i_write,
	input wire logic [fwsr_pkg::ADDR_W-1:0] i_addr,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_wdata,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_dq,
	output fwsr_pkg::fwsr_pins_t o_pins,
	output logic [fwsr_pkg::DATA_W-1:0] o_rdata,
	output logic o_done
);
	import fwsr_pkg::*;

	fwsr_cyc_state_t state_reg;
	logic [3:0] cnt_reg;
	logic write_reg;
	fwsr_pins_t pins_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic done_reg;

	assign o_pins = pins_reg;
	assign o_rdata = rdata_reg;
	assign o_done = done_reg;

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= C_IDLE;
			cnt_reg <= 4'h0;
			write_reg <= 1'b0;
			pins_reg <= PINS_IDLE;
			rdata_reg <= 8'h00;
			done_reg <= 1'b0;
		end else begin
			done_reg <= 1'b0;
			unique case (state_reg)
				C_IDLE: begin
					if (i_start) begin
						write_reg <= i_write;
						pins_reg.addr <= i_addr;
						pins_reg.dq <= i_wdata;
						pins_reg.dq_oe <= i_write;
						pins_reg.ce_n <= 1'b0;
						state_reg <= C_SETUP;
					end
				end
				C_SETUP: begin
					if (write_reg) begin
						pins_reg.we_n <= 1'b0;
						cnt_reg <= WR_PULSE_CYC - 4'h1;
					end else begin
						pins_reg.oe_n <= 1'b0;
						cnt_reg <= RD_ACC_CYC - 4'h1;
					end
					state_reg <= C_STROBE;
				end
				C_STROBE: begin
					if (cnt_reg == 4'h0) begin
						if (!write_reg) begin
							rdata_reg <= i_dq;
						end
						pins_reg.oe_n <= 1'b1;
						pins_reg.we_n <= 1'b1;
						cnt_reg <= RECOVER_CYC - 4'h1;
						state_reg <= C_RECOVER;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
				C_RECOVER: begin
					if (cnt_reg == 4'h0) begin
						pins_reg.ce_n <= 1'b1;
						pins_reg.dq_oe <= 1'b0;
						done_reg <= 1'b1;
						state_reg <= C_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 4'h1;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_strobe_excl: assert property (@(posedge i_clk) disable iff (i_reset)
		!(!pins_reg.oe_n && !pins_reg.we_n))
		else $error("output enable and write strobe low together");

	a_read_access: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(pins_reg.oe_n) |-> (!pins_reg.oe_n)[*4] ##1 pins_reg.oe_n)
		else $error("read strobe not held for the access time");

endmodule
`default_nettype wire

//--- fwsr_top.sv
/*
 Host-side flash status controller: AXI4-Lite register slave, flash bus
 sequencing, toggle-bit polling with timeout recheck and optional reset
 command, and checked writes that sample the erase-window flag.
 Assumes one 50 MHz clock, flash inputs synchronous to it, and the
 ready/busy line already pulled up outside.
*/
// Chosen here: the address map and the AXI4-Lite register port.
// Functional notes
// - Host combines sector and activity toggles to tell erasing from suspended.
// - Host reads status twice and compares; unchanged means finished.
// - Toggling with timeout flag high: retest once; still toggling means failure.
// - Polling that was interrupted restarts from its first double read.
// - After a timeout failure the host issues the reset command; here only when CTRL_AUTORST_BIT was set with GO.
// - Host may skip the window flag only with sub-50 us command spacing.
// - Host confirms acceptance by toggle before reading the window flag.
// - Host checks the window flag before and after each added erase command.
`default_nettype none
module fwsr_top (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [3:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [3:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	input wire logic [fwsr_pkg::DATA_W-1:0] i_dq,
	input wire logic i_ready_busy_line,
	output fwsr_pkg::fwsr_pins_t o_pins
);
	import fwsr_pkg::*;

	// ----------------------------------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------------------------------
	logic aw_have_reg, w_have_reg, bvalid_reg;
	logic [3:0] aw_addr_reg;
	logic [31:0] w_data_reg, wmask;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg;
	logic wr_fire, wr_mapped;

	assign o_awready = !aw_have_reg;
	assign o_wready = !w_have_reg;
	assign o_bvalid = bvalid_reg;
	assign o_bresp = bresp_reg;
	assign wr_fire = aw_have_reg && w_have_reg && !bvalid_reg;
	assign wr_mapped = (aw_addr_reg == OFS_CTRL) || (aw_addr_reg == OFS_ADDR) || (aw_addr_reg == OFS_WDATA)
		|| (aw_addr_reg == OFS_STATUS);

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_mask
			assign wmask[8*g +: 8] = {8{w_strb_reg[g]}};
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else begin
			if (i_awvalid && !aw_have_reg) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= i_awaddr;
			end else if (wr_fire) begin
				aw_have_reg <= 1'b0;
			end
			if (i_wvalid && !w_have_reg) begin
				w_have_reg <= 1'b1;
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
			end else if (wr_fire) begin
				w_have_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && i_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers and control strobes
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] cfg_addr_reg;
	logic [DATA_W-1:0] cfg_wdata_reg;
	logic ctrl_wr, start_req, abort_wr;
	fwsr_state_t state_reg, state_next;

	assign ctrl_wr = wr_fire && (aw_addr_reg == OFS_CTRL) && w_strb_reg[0];
	assign start_req = ctrl_wr && w_data_reg[CTRL_GO_BIT] && (state_reg == S_IDLE);
	assign abort_wr = ctrl_wr && w_data_reg[CTRL_ABORT_BIT];

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			cfg_addr_reg <= ADDR_RESET;
			cfg_wdata_reg <= WDATA_RESET;
		end else if (wr_fire && aw_addr_reg == OFS_ADDR) begin
			cfg_addr_reg <= ADDR_W'((32'(cfg_addr_reg) & ~wmask) | (w_data_reg & wmask));
		end else if (wr_fire && aw_addr_reg == OFS_WDATA && w_strb_reg[0]) begin
			cfg_wdata_reg <= w_data_reg[DATA_W-1:0];
		end
	end

	// ----------------------------------------------------------------
	// Flash bus cycle engine
	// ----------------------------------------------------------------
	logic cyc_start_reg, cyc_start_next, cyc_done, cyc_write;
	logic [DATA_W-1:0] cyc_rdata;

	assign cyc_write = (state_reg == S_WR) || (state_reg == S_RST);

	fwsr_bus_cycle u_cycle (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_start(cyc_start_reg),
		.i_write(cyc_write),
		.i_addr(cfg_addr_reg),
		.i_wdata((state_reg == S_RST) ? RESET_CMD_DATA : cfg_wdata_reg),
		.i_dq(i_dq),
		.o_pins(o_pins),
		.o_rdata(cyc_rdata),
		.o_done(cyc_done)
	);

	// ----------------------------------------------------------------
	// Polling sequencer
	// ----------------------------------------------------------------
	fwsr_op_t op_reg;
	fwsr_res_t result_reg, fin_result;
	logic autorst_reg, recheck_reg, recheck_next, abort_req_reg, fin;
	logic [DATA_W-1:0] first_reg, second_reg;
	logic act_toggled, sec_toggled;

	assign act_toggled = first_reg[ACTIVITY_TOGGLE_BIT] ^ second_reg[ACTIVITY_TOGGLE_BIT];
	assign sec_toggled = first_reg[SECTOR_TOGGLE_BIT] ^ second_reg[SECTOR_TOGGLE_BIT];

	always_comb begin
		state_next = state_reg;
		cyc_start_next = 1'b0;
		recheck_next = recheck_reg;
		fin = 1'b0;
		fin_result = RES_NONE;
		unique case (state_reg)
			S_IDLE: begin
				if (start_req) begin
					cyc_start_next = 1'b1;
					recheck_next = 1'b0;
					unique case (fwsr_op_t'(w_data_reg[CTRL_OP_LSB +: 2]))
						OP_WRITE: state_next = S_WR;
						OP_CHECKED: state_next = S_PRE;
						OP_READ, OP_POLL: state_next = S_RD1;
					endcase
				end
			end
			S_PRE: begin
				if (cyc_done) begin
					state_next = S_WR;
					cyc_start_next = 1'b1;
				end
			end
			S_WR: begin
				if (cyc_done && op_reg == OP_WRITE) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_XFER;
				end else if (cyc_done) begin
					state_next = S_RD1;
					cyc_start_next = 1'b1;
				end
			end
			S_RD1: begin
				if (cyc_done && op_reg == OP_READ) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_XFER;
				end else if (cyc_done) begin
					state_next = S_RD2;
					cyc_start_next = 1'b1;
				end
			end
			S_RD2: begin
				if (cyc_done) begin
					state_next = S_EVAL;
				end
			end
			S_EVAL: begin
				if (op_reg == OP_CHECKED) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_CHECKED;
				end else if (!act_toggled) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = (sec_toggled && !recheck_reg) ? RES_SUSPENDED : RES_DONE;
				end else if (recheck_reg && autorst_reg) begin
					state_next = S_RST;
					cyc_start_next = 1'b1;
				end else if (recheck_reg) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_FAIL;
				end else if (abort_req_reg) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_ABORTED;
				end else begin
					state_next = S_RD2;
					cyc_start_next = 1'b1;
					recheck_next = second_reg[TIMEOUT_FAIL_FLAG];
				end
			end
			S_RST: begin
				if (cyc_done) begin
					state_next = S_IDLE;
					fin = 1'b1;
					fin_result = RES_FAIL_RESET;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= S_IDLE;
			cyc_start_reg <= 1'b0;
			recheck_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cyc_start_reg <= cyc_start_next;
			recheck_reg <= recheck_next;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			op_reg <= OP_WRITE;
			autorst_reg <= 1'b0;
		end else if (start_req) begin
			op_reg <= fwsr_op_t'(w_data_reg[CTRL_OP_LSB +: 2]);
			autorst_reg <= w_data_reg[CTRL_AUTORST_BIT];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			abort_req_reg <= 1'b0;
		end else if (abort_wr) begin
			abort_req_reg <= 1'b1;
		end else if (start_req || fin) begin
			abort_req_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Status capture
	// ----------------------------------------------------------------
	logic pre_ewin_reg, accepted_reg, ewin_reg, reject_reg, done_reg;
	logic [DATA_W-1:0] last_rdata_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			first_reg <= 8'h00;
			second_reg <= 8'h00;
			pre_ewin_reg <= 1'b0;
			last_rdata_reg <= 8'h00;
		end else begin
			if (cyc_done && !cyc_write) begin
				last_rdata_reg <= cyc_rdata;
			end
			if (cyc_done && state_reg == S_PRE) begin
				pre_ewin_reg <= cyc_rdata[ERASE_WINDOW_FLAG];
			end
			if (cyc_done && state_reg == S_RD1) begin
				first_reg <= cyc_rdata;
			end else if (state_reg == S_EVAL && state_next == S_RD2) begin
				first_reg <= second_reg;
			end
			if (cyc_done && state_reg == S_RD2) begin
				second_reg <= cyc_rdata;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			accepted_reg <= 1'b0;
			ewin_reg <= 1'b0;
			reject_reg <= 1'b0;
		end else if (state_reg == S_EVAL && op_reg == OP_CHECKED) begin
			accepted_reg <= act_toggled;
			ewin_reg <= act_toggled && second_reg[ERASE_WINDOW_FLAG];
			reject_reg <= act_toggled && second_reg[ERASE_WINDOW_FLAG];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			done_reg <= 1'b0;
			result_reg <= RES_NONE;
		end else if (fin) begin
			done_reg <= 1'b1;
			result_reg <= fin_result;
		end else if (start_req) begin
			done_reg <= 1'b0;
			result_reg <= RES_NONE;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------------------------------
	logic rvalid_reg;
	logic [31:0] rdata_reg, status_word, rd_mux;
	logic [1:0] rresp_reg;
	logic rd_mapped;

	assign o_arready = !rvalid_reg;
	assign o_rvalid = rvalid_reg;
	assign o_rdata = rdata_reg;
	assign o_rresp = rresp_reg;

	always_comb begin
		status_word = 32'h0;
		status_word[ST_BUSY_BIT] = (state_reg != S_IDLE);
		status_word[ST_DONE_BIT] = done_reg;
		status_word[ST_RES_LSB +: 3] = result_reg;
		status_word[ST_RDY_BIT] = i_ready_busy_line;
		status_word[ST_REJ_BIT] = reject_reg;
		status_word[ST_EWIN_BIT] = ewin_reg;
		status_word[ST_RDATA_LSB +: 8] = last_rdata_reg;
		status_word[ST_ACC_BIT] = accepted_reg;
		status_word[ST_PRE_BIT] = pre_ewin_reg;
		rd_mapped = 1'b1;
		unique case (i_araddr)
			OFS_CTRL: rd_mux = {28'h0, autorst_reg, op_reg, 1'b0};
			OFS_ADDR: rd_mux = 32'(cfg_addr_reg);
			OFS_WDATA: rd_mux = 32'(cfg_wdata_reg);
			OFS_STATUS: rd_mux = status_word;
			default: begin
				rd_mux = 32'h0;
				rd_mapped = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0;
			rresp_reg <= RESP_OKAY;
		end else if (i_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_mux;
			rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && i_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	logic [2:0] rd_count_reg;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rd_count_reg <= 3'h0;
		end else if (start_req) begin
			rd_count_reg <= 3'h0;
		end else if (cyc_done && (state_reg == S_RD1 || state_reg == S_RD2) && rd_count_reg != 3'h7) begin
			rd_count_reg <= rd_count_reg + 3'h1;
		end
	end

	a_double_read: assert property (@(posedge i_clk) disable iff (i_reset)
		state_reg == S_EVAL |-> rd_count_reg >= 3'h2)
		else $error("toggle evaluated before two reads");

	a_mode_combine: assert property (@(posedge i_clk) disable iff (i_reset)
		fin && fin_result == RES_SUSPENDED |-> sec_toggled && !act_toggled)
		else $error("suspend reported without sector toggle");

	a_timeout_recheck: assert property (@(posedge i_clk) disable iff (i_reset)
		state_reg == S_EVAL && op_reg != OP_CHECKED && act_toggled && !recheck_reg && !abort_req_reg
		&& second_reg[TIMEOUT_FAIL_FLAG] |=> state_reg == S_RD2 && recheck_reg)
		else $error("timeout flag not followed by retest");

	a_fail_reset: assert property (@(posedge i_clk) disable iff (i_reset)
		state_reg == S_EVAL && op_reg != OP_CHECKED && act_toggled && recheck_reg && autorst_reg
		|=> state_reg == S_RST ##1 o_pins.dq == RESET_CMD_DATA && o_pins.dq_oe)
		else $error("failure not followed by reset command");

	a_poll_restart: assert property (@(posedge i_clk) disable iff (i_reset)
		start_req |=> !recheck_reg && (state_reg == S_RD1 || state_reg == S_WR || state_reg == S_PRE))
		else $error("polling did not restart from the first read");

	a_accept_first: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(ewin_reg) |-> $past(act_toggled) && $past(op_reg == OP_CHECKED))
		else $error("window flag taken before acceptance");

	a_check_both: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_reg == S_WR) && op_reg == OP_CHECKED |-> $past(state_reg) == S_PRE)
		else $error("checked write lacks a prior window check");

	a_window_used: assert property (@(posedge i_clk) disable iff (i_reset)
		fin && fin_result == RES_CHECKED |=> done_reg && reject_reg == ewin_reg
		&& ewin_reg == (accepted_reg && $past(second_reg[ERASE_WINDOW_FLAG])))
		else $error("rejection flag does not follow window flag");

	c_poll_done: cover property (@(posedge i_clk) disable iff (i_reset) fin && fin_result == RES_DONE);
	c_poll_fail: cover property (@(posedge i_clk) disable iff (i_reset) fin && fin_result == RES_FAIL_RESET);
	c_suspended: cover property (@(posedge i_clk) disable iff (i_reset) fin && fin_result == RES_SUSPENDED);
	c_checked: cover property (@(posedge i_clk) disable iff (i_reset) fin && fin_result == RES_CHECKED);

endmodule
`default_nettype wire

//--- fwsr_flash_model.sv
/* Behavioural flash status model on the controller's pins.
 Assumes the pins come straight from the controller. */
`default_nettype none
module fwsr_flash_model (
	input wire fwsr_pkg::fwsr_pins_t i_pins,
	output logic [7:0] o_dq,
	output logic o_ready_busy_line
);
	timeunit 1ns;
	timeprecision 1ps;
	import fwsr_pkg::*;
	logic [26:0] last_wr = 27'h0;
	int left = 0;
	int resets = 0;
	logic tog = 1'b0, tog2 = 1'b0, fail = 1'b0, win = 1'b0, susp = 1'b0;
	logic [7:0] stat;
	task automatic arm(input int n, input logic f, w, s);
		left = n;
		fail = f;
		win = w;
		susp = s;
	endtask
	assign stat = {left == 0, tog, fail, 1'b0, win, tog2, 2'b00};
	// Released bus shows the inverse, never a stale value
	assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? stat : ~stat;
	assign o_ready_busy_line = (left == 0);
	always @(negedge i_pins.oe_n) begin
		if (!i_pins.ce_n && left > 0) begin
			tog = ~tog;
			if (!fail) left--;
		end
		if (!i_pins.ce_n && (susp || left > 0)) tog2 = ~tog2;
	end
	always @(posedge i_pins.we_n) begin
		last_wr = {i_pins.addr, i_pins.dq};
		if (i_pins.dq == RESET_CMD_DATA) begin
			left = 0;
			fail = 1'b0;
			resets++;
		end
	end
endmodule
`default_nettype wire

//--- fwsr_top_test.sv
/* Self-checking bench of the flash status controller.
 Assumes the flash model answers within one read strobe. */
`default_nettype none
module fwsr_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import fwsr_pkg::*;
	logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [3:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rd, rdata;
	logic awready, wready, bvalid, arready, rvalid, rb;
	logic [1:0] bresp, rresp, rr, br;
	logic [7:0] dq;
	fwsr_pins_t pins;
	int mismatches = 0, num_checks = 0;
	always #10 clk = ~clk;
	fwsr_top i_dut (.i_clk(clk), .i_reset(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
		.i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_dq(pins.dq_oe ? pins.dq : dq),
		.i_ready_busy_line(rb), .o_pins(pins));
	fwsr_flash_model i_flash (.i_pins(pins), .o_dq(dq), .o_ready_busy_line(rb));
	task automatic chk(input string n, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic pa = 1'b1, pw = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge clk);
			if (awready) pa = 1'b0;
			if (wready) pw = 1'b0;
			awvalid <= pa;
			wvalid <= pw;
		end
		do @(posedge clk); while (!bvalid);
		br = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk);
		rd = rdata;
		rr = rresp;
		rready <= 1'b0;
	endtask
	task automatic run(input logic [1:0] op, input logic [1:0] ar, input logic [2:0] res);
		wr(OFS_CTRL, {27'h0, ar, op, 1'b1});
		rd = '0;
		for (int i = 0; i < 300 && rd[ST_DONE_BIT] !== 1'b1; i++) rd_reg(OFS_STATUS);
		chk("result", 32'(rd[4:2]), 32'(res));
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1ms;
		mismatches++;
		conclude();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd_reg(OFS_STATUS);
		chk("status", 32'(rd[5:0]), 32'h20);
		rd_reg(4'h2);
		chk("rresp", 32'(rr), 32'(RESP_SLVERR));
		wr(4'h2, 32'h0);
		chk("bresp", 32'(br), 32'(RESP_SLVERR));
		run(OP_POLL, 2'b00, RES_DONE);
		wr(OFS_ADDR, 32'h12345);
		chk("bresp okay", 32'(br), 32'(RESP_OKAY));
		wr(OFS_WDATA, 32'h5a);
		run(OP_WRITE, 2'b00, RES_XFER);
		chk("write cycle", 32'(i_flash.last_wr), 32'h0123455a);
		i_flash.arm(10, 1'b0, 1'b1, 1'b0);
		run(OP_CHECKED, 2'b00, RES_CHECKED);
		chk("window", 32'({rd[17:16], rd[7:6]}), 32'hf);
		run(OP_POLL, 2'b00, RES_DONE);
		i_flash.arm(0, 1'b0, 1'b0, 1'b1);
		run(OP_POLL, 2'b00, RES_SUSPENDED);
		i_flash.arm(1000, 1'b1, 1'b0, 1'b0);
		rd_reg(OFS_STATUS);
		chk("busy line", 32'(rd[ST_RDY_BIT]), 32'h0);
		run(OP_POLL, 2'b00, RES_FAIL);
		run(OP_POLL, 2'b01, RES_FAIL_RESET);
		chk("reset cmds", 32'(i_flash.resets), 32'h1);
		i_flash.arm(1000, 1'b0, 1'b0, 1'b0);
		run(OP_POLL, 2'b10, RES_ABORTED);
		i_flash.arm(0, 1'b0, 1'b0, 1'b0);
		run(OP_READ, 2'b00, RES_XFER);
		chk("byte", 32'(rd[15:8]), 32'(i_flash.stat));
		rd_reg(OFS_CTRL);
		chk("ctrl", rd, 32'h2);
		rd_reg(OFS_ADDR);
		chk("addr", rd, 32'h12345);
		conclude();
	end
endmodule
`default_nettype wire
